// file: common/slc_map.vh
/*
 * Constants for the strap capture and LED pin sharing block.
 * Assumes inclusion by bare name from the design file; the bench files do not include it.
 */
`ifndef SLC_MAP_VH
`define SLC_MAP_VH

// ****************************************
// strap widths and reset values
// ****************************************
`define SLC_ADDR_W 5
`define SLC_MODE_W 3
`define SLC_ADDR_RST 5'h00
`define SLC_MODE_RST 3'h7
`define SLC_XOVER_RST 1'h1
`define SLC_SWAP_RST 1'h1
`define SLC_RMII_RST 1'h0
`define SLC_IRQSEL_RST 1'h1
`define SLC_LED_RST 1'h0
`define SLC_GPO_RST 1'h0
`define SLC_IRQ_N_RST 1'h1
// bit positions of the captured straps when packed into one word
`define SLC_POS_ADDR 0
`define SLC_POS_MODE 5
`define SLC_POS_XOVER 8
`define SLC_POS_SWAP 9
`define SLC_POS_RMII 10
`define SLC_POS_IRQSEL 11
`define SLC_WORD_W 12
// led polarity: 1 means a driven high level is the active state
`define SLC_LED_ACTIVE 1'h1

`endif

// file: dv/slc_board.sv
/* board side: strap resistors on the shared pins
   assumes strap levels come from the bench */
`timescale 1ns/1ps
module slc_board (
    input wire [5:0] i_strap,
    input wire [5:0] i_out,
    input wire [5:0] i_oe,
    output wire [5:0] o_pad
);
    // an undriven pin shows its resistor level, never the last driven one
    assign o_pad = (i_oe & i_out) | (~i_oe & i_strap);
endmodule

// file: dv/slc_props.sv
/* checker of strap capture, led lag and shared pin drive timing
   assumes it is bound onto slc_strap_led_config */
`timescale 1ns/1ps
module slc_props (
    input wire i_clock, i_rst, i_ext_reset_n, i_speed_is_100, i_link_up,
    input wire i_xover_override_en, i_xover_override_val, o_speed_led, o_link_led,
    input wire o_auto_crossover_on, o_general_output_zero_oe,
    input wire [4:0] i_addr_strap_pin, o_addr_default, o_shared_pin_oe,
    input wire [2:0] i_mode_pin, o_mode_default
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    a_addr_cap: assert property (
        $rose(i_ext_reset_n) |=> o_addr_default == $past(i_addr_strap_pin)) else $error("addr");
    a_mode_cap: assert property (
        $rose(i_ext_reset_n) |=> o_mode_default == $past(i_mode_pin)) else $error("mode");
    // first edge after reset may latch too, so it is left out
    a_addr_hold: assert property (
        !$rose(i_ext_reset_n) && !$past(i_rst) |=> $stable(o_addr_default)) else $error("hold");
    a_oe_low: assert property (
        !i_ext_reset_n |=> o_shared_pin_oe == 5'h00 && !o_general_output_zero_oe)
        else $error("oe low");
    a_oe_rise: assert property (
        $rose(i_ext_reset_n) ##1 i_ext_reset_n |=> &o_shared_pin_oe && o_general_output_zero_oe)
        else $error("oe rise");
    a_speed_lag: assert property (
        ##1 o_speed_led == $past(i_speed_is_100)) else $error("speed");
    a_link_lag: assert property (
        ##1 o_link_led == $past(i_link_up)) else $error("link");
    a_xover_ovr: assert property (
        i_xover_override_en |=> o_auto_crossover_on == $past(i_xover_override_val))
        else $error("xover");
endmodule
bind slc_strap_led_config slc_props u_props (
    .i_clock(i_clock), .i_rst(i_rst), .i_ext_reset_n(i_ext_reset_n),
    .i_speed_is_100(i_speed_is_100), .i_link_up(i_link_up),
    .i_xover_override_en(i_xover_override_en), .i_xover_override_val(i_xover_override_val),
    .o_speed_led(o_speed_led), .o_link_led(o_link_led), .o_auto_crossover_on(o_auto_crossover_on),
    .o_general_output_zero_oe(o_general_output_zero_oe), .i_addr_strap_pin(i_addr_strap_pin),
    .o_addr_default(o_addr_default), .o_shared_pin_oe(o_shared_pin_oe),
    .i_mode_pin(i_mode_pin), .o_mode_default(o_mode_default)
);

// file: dv/slc_strap_led_config_test.sv
/* self-checking bench: random straps and status every cycle, external
   reset pulsed low; assumes the board model resolves the shared pins */
`timescale 1ns/1ps
module slc_strap_led_config_test;
    logic i_clock = 0, i_rst = 1, i_ext_reset_n = 0, pe = 0;
    logic [10:0] r = 0;
    logic [11:0] s = 0, c = 12'hBE0; // c starts at the reset defaults
    logic [28:0] q[$];
    int err_total = 0, checks = 0, k;
    wire i_speed_is_100, i_link_up, i_carrier_detect, i_full_duplex, i_rx_nibble_valid;
    wire i_xover_override_en, i_xover_override_val, i_general_output_zero_ctrl, i_general_output_one_ctrl, i_irq_event;
    wire i_tx_error, i_auto_crossover_enable, i_pair_swap_select, i_irq_pin_function_strap;
    wire i_general_output_zero_pin, o_rmii_mode, o_irq_select, o_auto_crossover_on;
    wire o_pair_swap_mdix, o_speed_led, o_link_led, o_activity_led, o_full_dup_led;
    wire o_general_output_one, o_general_output_zero, o_general_output_zero_oe, o_irq_out_n;
    wire o_irq_pin_oe, o_tx_error_in, o_carrier_sense, o_rx_data_valid;
    wire [4:0] i_addr_strap_pin, o_addr_default, o_shared_pin_oe;
    wire [2:0] i_mode_pin, o_mode_default;
    wire [28:0] obs = {o_addr_default, o_mode_default, o_rmii_mode, o_irq_select,
        o_auto_crossover_on, o_pair_swap_mdix, o_speed_led, o_link_led, o_activity_led,
        o_full_dup_led, o_general_output_one, o_general_output_zero, o_shared_pin_oe,
        o_general_output_zero_oe, o_irq_out_n, o_irq_pin_oe, o_tx_error_in, o_carrier_sense,
        o_rx_data_valid};
    assign {i_tx_error, i_irq_event, i_general_output_one_ctrl, i_general_output_zero_ctrl, i_xover_override_val,
        i_xover_override_en, i_rx_nibble_valid, i_full_duplex, i_carrier_detect, i_link_up,
        i_speed_is_100} = r;
    assign {i_irq_pin_function_strap, i_pair_swap_select, i_auto_crossover_enable} = {s[11], s[9:8]};
    assign i_mode_pin = s[7:5];
    // ****************************************
    // design and board
    // ****************************************
    slc_strap_led_config DUT (.*);
    slc_board board (.i_strap({s[10], s[4:0]}), .i_oe({o_general_output_zero_oe, o_shared_pin_oe}),
        .i_out({o_general_output_zero, o_general_output_one, o_full_dup_led, o_activity_led,
        o_link_led, o_speed_led}), .o_pad({i_general_output_zero_pin, i_addr_strap_pin}));
    initial forever #5 i_clock = ~i_clock;
    task chk(input logic [28:0] seen, input logic [28:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value outputs expected %h seen %h", exp, seen);
        end
    endtask
    task end_of_test;
        if (err_total == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // driver: no note on the release edge itself, where the new straps and
    // the old interrupt role mix in one cycle's outputs
    initial begin
        void'($urandom(25));
        repeat (8) @(posedge i_clock);
        i_rst <= 0;
        for (k = 0; k < 400; k++) begin
            @(posedge i_clock);
            if (i_ext_reset_n && !pe) c = s;
            if (!i_ext_reset_n || pe) q.push_back({c[4:0], c[7:5], c[10], c[11],
                r[5] ? r[6] : c[8], c[9], r[0], r[1], r[2], r[3], r[8], r[7],
                {6{i_ext_reset_n & pe}}, c[11] ? ~r[9] : 1'h1, c[11] & i_ext_reset_n & pe,
                r[10] & ~c[11], r[2], r[4] & ~c[10]});
            pe = i_ext_reset_n;
            r <= 11'($urandom);
            s <= 12'($urandom);
            i_ext_reset_n <= k % 16 > 3;
        end
        repeat (2) @(negedge i_clock);
        end_of_test;
    end
    // monitor: settled outputs against the oldest note
    always @(negedge i_clock) if (q.size() > 0) chk(obs, q.pop_front());
    // watchdog, about half again the planned run of some 4090 ns
    initial begin
        #6000;
        err_total++;
        end_of_test;
    end
endmodule

// file: hdl/slc_strap_led_config.v
/*
 * Strap capture at external reset release and the later reuse of the same
 * pins as LED outputs, general outputs and the interrupt pin.
 * Assumes all inputs are synchronous to i_clock; pad wiring resolves each
 * pin from its output and output enable; strap pins read 1 when floating.
 */
`timescale 1ns/1ps
`include "slc_map.vh"

module slc_strap_led_config #(
    parameter ADDR_W = `SLC_ADDR_W,
    parameter MODE_W = `SLC_MODE_W
) (
    input wire i_clock,
    input wire i_rst,
    input wire i_ext_reset_n,
    input wire [ADDR_W-1:0] i_addr_strap_pin,
    input wire [MODE_W-1:0] i_mode_pin,
    input wire i_auto_crossover_enable,
    input wire i_pair_swap_select,
    input wire i_general_output_zero_pin,
    input wire i_irq_pin_function_strap,
    input wire i_speed_is_100,
    input wire i_link_up,
    input wire i_carrier_detect,
    input wire i_full_duplex,
    input wire i_rx_nibble_valid,
    input wire i_xover_override_en,
    input wire i_xover_override_val,
    input wire i_general_output_zero_ctrl,
    input wire i_general_output_one_ctrl,
    input wire i_irq_event,
    input wire i_tx_error,
    output reg [ADDR_W-1:0] o_addr_default,
    output reg [MODE_W-1:0] o_mode_default,
    output reg o_rmii_mode,
    output reg o_irq_select,
    output reg o_auto_crossover_on,
    output reg o_pair_swap_mdix,
    output reg o_speed_led,
    output reg o_link_led,
    output reg o_activity_led,
    output reg o_full_dup_led,
    output reg o_general_output_one,
    output reg o_general_output_zero,
    output reg [ADDR_W-1:0] o_shared_pin_oe,
    output reg o_general_output_zero_oe,
    output reg o_irq_out_n,
    output reg o_irq_pin_oe,
    output reg o_tx_error_in,
    output reg o_carrier_sense,
    output reg o_rx_data_valid
);

    // ****************************************
    // strap capture
    // ****************************************
    reg ext_reset_n_q;
    reg captured;
    reg xover_strap;
    reg swap_strap;
    wire release_edge;

    // previous level of external reset, for its rising edge; it clears to the
    // asserted level so a pin already high after the core reset still latches
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ext_reset_n_q <= 1'h0;
        end else begin
            ext_reset_n_q <= i_ext_reset_n;
        end
    end

    assign release_edge = i_ext_reset_n & ~ext_reset_n_q;

    // pads may drive only while straps are held and external reset is high;
    // any low level releases them at the next edge
    wire pads_may_drive;
    assign pads_may_drive = captured & i_ext_reset_n;

    // ****************************************
    // helpers
    // ****************************************
    // one place decides the pin level of a lit led, shared by all four leds
    function led_level;
        input status;
        begin
            led_level = status ? `SLC_LED_ACTIVE : ~`SLC_LED_ACTIVE;
        end
    endfunction

    // straps latched by a clocked process at release, never by the async
    // reset, so the reset branch only ever loads constants
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_addr_default <= `SLC_ADDR_RST;
            o_mode_default <= `SLC_MODE_RST;
            xover_strap <= `SLC_XOVER_RST;
            swap_strap <= `SLC_SWAP_RST;
            o_rmii_mode <= `SLC_RMII_RST;
            o_irq_select <= `SLC_IRQSEL_RST;
            captured <= 1'h0;
        end else if (!i_ext_reset_n) begin
            captured <= 1'h0;
        end else if (release_edge) begin
            o_addr_default <= i_addr_strap_pin;
            o_mode_default <= i_mode_pin;
            xover_strap <= i_auto_crossover_enable;
            swap_strap <= i_pair_swap_select;
            o_rmii_mode <= i_general_output_zero_pin;
            o_irq_select <= i_irq_pin_function_strap;
            captured <= 1'h1;
        end
    end

    // ****************************************
    // crossover settings
    // ****************************************
    // the override bit wins over the strap so software can repair a bad strap
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_auto_crossover_on <= `SLC_XOVER_RST;
            o_pair_swap_mdix <= `SLC_SWAP_RST;
        end else begin
            if (i_xover_override_en) begin
                o_auto_crossover_on <= i_xover_override_val;
            end else begin
                o_auto_crossover_on <= xover_strap;
            end
            // the pair choice passes through whether auto crossover is on or off
            o_pair_swap_mdix <= swap_strap;
        end
    end

    // ****************************************
    // status leds on the shared pins
    // ****************************************
    // leds follow status one cycle late; the pad enable keeps them off the
    // pins until the straps are held, so a lit led cannot spoil a strap
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_speed_led <= `SLC_LED_RST;
            o_link_led <= `SLC_LED_RST;
            o_activity_led <= `SLC_LED_RST;
            o_full_dup_led <= `SLC_LED_RST;
        end else begin
            o_speed_led <= led_level(i_speed_is_100);
            o_link_led <= led_level(i_link_up);
            o_activity_led <= led_level(i_carrier_detect);
            o_full_dup_led <= led_level(i_full_duplex);
        end
    end

    // ****************************************
    // general outputs
    // ****************************************
    // control bits pass through one flop; output one shares the address bit 4
    // pin, output zero the mii or rmii strap pin
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_general_output_one <= `SLC_GPO_RST;
            o_general_output_zero <= `SLC_GPO_RST;
        end else begin
            o_general_output_one <= i_general_output_one_ctrl;
            o_general_output_zero <= i_general_output_zero_ctrl;
        end
    end

    // ****************************************
    // pad drive enables
    // ****************************************
    // every enable drops one edge after the external reset goes low, which
    // leaves only the board resistors on the pins by the time of release
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_shared_pin_oe <= {ADDR_W{1'h0}};
            o_general_output_zero_oe <= 1'h0;
            o_irq_pin_oe <= 1'h0;
        end else begin
            o_shared_pin_oe <= {ADDR_W{pads_may_drive}};
            o_general_output_zero_oe <= pads_may_drive;
            // the interrupt pin is only driven in its interrupt role
            o_irq_pin_oe <= pads_may_drive & o_irq_select;
        end
    end

    // ****************************************
    // interrupt or transmit error pin
    // ****************************************
    // the strap picks one role for the shared pin; the unused role idles at
    // its inactive level, interrupt high and transmit error low
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_irq_out_n <= `SLC_IRQ_N_RST;
            o_tx_error_in <= 1'h0;
        end else begin
            o_irq_out_n <= ~(o_irq_select & i_irq_event);
            o_tx_error_in <= ~o_irq_select & i_tx_error;
        end
    end

    // ****************************************
    // receive status outputs
    // ****************************************
    // receive valid is held low in rmii where the pin has no use
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_carrier_sense <= 1'h0;
            o_rx_data_valid <= 1'h0;
        end else begin
            o_carrier_sense <= i_carrier_detect;
            o_rx_data_valid <= i_rx_nibble_valid & ~o_rmii_mode;
        end
    end

endmodule
